/* core/qwrp_pkg.sv */
// constants and types for the quad read, wrap and page program sequencer
// assumes one 20 MHz system clock and pins sampled through synchronisers
package qwrp_pkg;

    // =====================================================================
    // opcodes
    localparam logic [7:0] OP_READ_QUAD  = 8'heb;
    localparam logic [7:0] OP_READ_WORD  = 8'he7;
    localparam logic [7:0] OP_READ_OCTAL = 8'he3;
    localparam logic [7:0] OP_SET_WRAP   = 8'h77;
    localparam logic [7:0] OP_PAGE_PROG  = 8'h02;

    // =====================================================================
    // phase lengths in serial clocks: last index of each phase, dummy clock counts
    localparam logic [4:0] OP_LAST        = 5'h07;
    localparam logic [4:0] QADDR_LAST     = 5'h05;
    localparam logic [4:0] MODE_LAST      = 5'h01;
    localparam logic [4:0] WRAP_DUM_LAST  = 5'h05;
    localparam logic [4:0] WRAP_BITS_LAST = 5'h01;
    localparam logic [4:0] SADDR_LAST     = 5'h17;
    localparam logic [4:0] BYTE_LAST      = 5'h07;
    localparam logic [4:0] DUMMY_QUAD     = 5'h04;
    localparam logic [4:0] DUMMY_WORD     = 5'h02;
    localparam logic [4:0] DUMMY_OCTAL    = 5'h00;

    // =====================================================================
    // field positions and codes
    localparam int         MODE_CONT_HI   = 5;
    localparam int         MODE_CONT_LO   = 4;
    localparam logic [1:0] MODE_CONT_CODE = 2'h2;
    localparam int         WRAP_DIS_POS   = 4;
    localparam int         WRAP_LEN_HI    = 6;
    localparam int         WRAP_LEN_LO    = 5;
    localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;
    localparam logic       WRAP_DIS_RST   = 1'b1;
    localparam logic [1:0] WRAP_LEN_RST   = 2'h0;
    localparam int         PAGE_BYTES     = 256;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int PROG_TIME_NS_DEF = 700000;

    typedef enum logic [3:0] {
        S_IDLE, S_OPCODE, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_WRAP_DUM,
        S_WRAP_BITS, S_PP_ADDR, S_PP_DATA, S_IGNORE
    } qwrp_state_t;

endpackage : qwrp_pkg

/* core/qwrp_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the inputs are levels that stay put for several clocks
module qwrp_sync
    import qwrp_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinOut
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } qwrp_sync_t;

    qwrp_sync_t s, n;

    if (W < 1) begin : g_bad_width
        $error("qwrp_sync width must be at least one");
    end

    // =====================================================================
    // first stage feeds only the second
    always_comb begin
        n.s1 = pinIn;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign pinOut = s.s2;

endmodule : qwrp_sync

/* core/qwrp_page_buf.sv */
// page buffer holding program bytes and a loaded flag per byte
// assumes one write per clock and a combinational read port
module qwrp_page_buf
    import qwrp_pkg::*;
#(
    parameter int BYTES = qwrp_pkg::PAGE_BYTES
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     clearAll,
    input  wire logic                     wrEn,
    input  wire logic [$clog2(BYTES)-1:0] wrIdx,
    input  wire logic [7:0]               wrData,
    input  wire logic [$clog2(BYTES)-1:0] rdIdx,
    output logic      [7:0]               rdData,
    output logic                          rdValid
);

    typedef struct packed {
        logic [BYTES-1:0] loaded;
    } qwrp_buf_t;

    qwrp_buf_t  s, n;
    logic [7:0] mem [BYTES];

    if (BYTES != PAGE_BYTES) begin : g_bad_size
        $error("qwrp_page_buf must hold exactly one page");
    end

    // =====================================================================
    // loaded flags: a write in the clearing cycle still counts
    always_comb begin
        n = s;
        if (clearAll) begin
            n.loaded = '0;
        end
        if (wrEn) begin
            n.loaded[wrIdx] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // byte store, overwritten when the page address wraps
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    assign rdData  = mem[rdIdx];
    assign rdValid = s.loaded[rdIdx];

    chk_write_marks: assert property (
        @(posedge clk) disable iff (!reset_n)
        wrEn |=> s.loaded[$past(wrIdx)])
        else $error("written byte not marked loaded");

endmodule : qwrp_page_buf

/* core/qwrp_sequencer.sv */
// serial flash sequencer: quad word reads, burst wrap setting, page program
// assumes spi mode 0 pins sampled by clk; memory array and status outside
// Operation
// - word quad read waits two dummy clocks after mode bits
// - word and octal word reads need the quad enable bit set
// - eight mode bits follow the address; only upper nibble matters
// - mode bits 5:4 equal 10 make the next select skip the opcode
// - any other mode bits 5:4 return to full opcode decoding
// - octal word read outputs data straight after the mode bits
// - wrap setting is opcode, 24 dummy bits, eight wrap bits
// - wrap bit 4 low enables wrap; bits 6:5 pick 8 to 64 bytes
// - stored wrap setting applies to later quad and word quad reads
// - wrap starts disabled after power on
// - wrapped output restarts at section start until select rises
// - four lane wrapped reads reuse the stored wrap length
// - page program needs the write enable latch, address, data bytes
// - program data advances only the low address byte, wrapping
// - program runs only if select rises on a byte boundary
// - busy flag high during the self timed program cycle
// - write enable latch clears at the end; protected pages skipped
module qwrp_sequencer
    import qwrp_pkg::*;
#(
    parameter int PROG_TIME_NS = PROG_TIME_NS_DEF
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOe,
    input  wire logic        quadEnableBit,
    input  wire logic        welSet,
    input  wire logic        pageProtected,
    output logic             writeEnableLatch,
    output logic             programBusyFlag,
    output logic             continuousReadMode,
    output logic             wrapDisableBit,
    output logic      [1:0]  wrapLengthField,
    output logic      [23:0] progAddr,
    output logic      [23:0] memRdAddr,
    input  wire logic [7:0]  memRdData,
    output logic             arrWrEn,
    output logic      [23:0] arrWrAddr,
    output logic      [7:0]  arrWrData
);

    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CW          = $clog2(PROG_CYCLES);

    if (PROG_CYCLES <= PAGE_BYTES) begin : g_bad_time
        $error("program time too short to move a page");
    end

    typedef struct packed {
        qwrp_state_t st;
        logic [4:0]  cnt;
        logic [23:0] sh;
        logic [7:0]  op;
        logic [23:0] addr;
        logic        phase;
        logic [7:0]  outByte;
        logic [3:0]  ioOut;
        logic [3:0]  ioOe;
        logic        sclkPrev;
        logic        csPrev;
        logic        contMode;
        logic [7:0]  contOp;
        logic        wrapDis;
        logic [1:0]  wrapLen;
        logic        gotByte;
        logic        write_enable_latch;
        logic        busy;
        logic [CW-1:0] progCnt;
        logic [23:0] progAddr;
        logic        arrWrEn;
        logic [23:0] arrWrAddr;
        logic [7:0]  arrWrData;
    } qwrp_seq_t;

    qwrp_seq_t  s, n;
    logic [5:0] pinS;
    logic       csS, sclkS, rise, fall, csRise, io0;
    logic [3:0] ioS;
    logic       bufClear, bufWrEn, bufValid;
    logic [7:0] bufRdData;
    logic [7:0] modeBits, wrapBits;

    // =====================================================================
    // dummy clocks after the mode bits for each read opcode
    function automatic logic [4:0] dummyClks(input logic [7:0] op);
        case (op)
            OP_READ_WORD:  dummyClks = DUMMY_WORD;
            OP_READ_OCTAL: dummyClks = DUMMY_OCTAL;
            default:       dummyClks = DUMMY_QUAD;
        endcase
    endfunction : dummyClks

    // next read address, held inside the aligned section when wrapping
    function automatic logic [23:0] nextReadAddr(input logic [23:0] a,
                                                 input logic        wrapOn,
                                                 input logic [1:0]  len);
        logic [7:0] mask;
        logic [7:0] low;
        mask = 8'((WRAP_MIN_BYTES << len) - 8'h01);
        low  = (a[7:0] & ~mask) | ((a[7:0] + 8'h01) & mask);
        nextReadAddr = wrapOn ? {a[23:8], low} : a + 24'h000001;
    endfunction : nextReadAddr

    // =====================================================================
    // pin synchronisers, edges found from the second stage onward
    // select travels inverted so a flushed stage reads as deselected,
    // which keeps reset from faking a select fall and a later rise
    qwrp_sync #(
        .W (6)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pinIn   ({~csN, sclk, ioIn}),
        .pinOut  (pinS)
    );

    assign csS    = ~pinS[5];
    assign sclkS  = pinS[4];
    assign ioS    = pinS[3:0];
    assign io0    = pinS[0];
    assign rise   = sclkS & ~s.sclkPrev;
    assign fall   = ~sclkS & s.sclkPrev;
    assign csRise = csS & ~s.csPrev;

    assign modeBits = {s.sh[3:0], ioS};
    assign wrapBits = {s.sh[3:0], ioS};

    // page buffer, streamed to the array during the program cycle
    qwrp_page_buf u_buf (
        .clk      (clk),
        .reset_n  (reset_n),
        .clearAll (bufClear),
        .wrEn     (bufWrEn),
        .wrIdx    (s.addr[7:0]),
        .wrData   ({s.sh[6:0], io0}),
        .rdIdx    (s.progCnt[7:0]),
        .rdData   (bufRdData),
        .rdValid  (bufValid)
    );

    // =====================================================================
    // next state of the whole sequencer
    always_comb begin
        n          = s;
        bufClear   = 1'b0;
        bufWrEn    = 1'b0;
        n.sclkPrev = sclkS;
        n.csPrev   = csS;
        n.arrWrEn  = 1'b0;
        // self-timed program cycle
        if (s.busy) begin
            if (s.progCnt < CW'(PAGE_BYTES)) begin
                n.arrWrEn   = bufValid;
                n.arrWrAddr = {s.progAddr[23:8], s.progCnt[7:0]};
                n.arrWrData = bufRdData;
            end
            if (s.progCnt == CW'(PROG_CYCLES - 1)) begin
                n.busy = 1'b0;
                n.write_enable_latch  = 1'b0;
            end else begin
                n.progCnt = s.progCnt + 1'b1;
            end
        end
        if (welSet) begin
            n.write_enable_latch = 1'b1;
        end
        if (csS) begin
            // select high ends every instruction; program only on byte edge
            if (csRise && s.st == S_PP_DATA && s.cnt == '0 && s.gotByte
                    && !pageProtected && !s.busy) begin
                n.busy    = 1'b1;
                n.progCnt = '0;
            end
            n.st   = S_IDLE;
            n.ioOe = 4'h0;
        end else begin
            case (s.st)
                S_IDLE: begin
                    n.cnt     = '0;
                    n.phase   = 1'b0;
                    n.gotByte = 1'b0;
                    if (s.busy) begin
                        n.st = S_IGNORE;
                    end else if (s.contMode) begin
                        n.op = s.contOp;
                        n.st = S_ADDR;
                    end else begin
                        n.st = S_OPCODE;
                    end
                end
                S_OPCODE: if (rise) begin
                    n.sh  = {s.sh[22:0], io0};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == OP_LAST) begin
                        n.cnt = '0;
                        n.op  = {s.sh[6:0], io0};
                        case ({s.sh[6:0], io0})
                            OP_READ_QUAD, OP_READ_WORD, OP_READ_OCTAL:
                                n.st = quadEnableBit ? S_ADDR : S_IGNORE;
                            OP_SET_WRAP:
                                n.st = S_WRAP_DUM;
                            OP_PAGE_PROG: begin
                                n.st     = s.write_enable_latch ? S_PP_ADDR : S_IGNORE;
                                bufClear = 1'b1;
                            end
                            default:
                                n.st = S_IGNORE;
                        endcase
                    end
                end
                S_ADDR: if (rise) begin
                    // low address bits taken as given by the host
                    n.sh  = {s.sh[19:0], ioS};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == QADDR_LAST) begin
                        n.addr = {s.sh[19:0], ioS};
                        n.cnt  = '0;
                        n.st   = S_MODE;
                    end
                end
                S_MODE: if (rise) begin
                    n.sh  = {s.sh[19:0], ioS};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == MODE_LAST) begin
                        // lower nibble of the mode byte is ignored
                        n.contMode = modeBits[MODE_CONT_HI:MODE_CONT_LO]
                                     == MODE_CONT_CODE;
                        n.contOp   = s.op;
                        n.cnt      = '0;
                        n.st       = (dummyClks(s.op) == '0) ? S_DATA : S_DUMMY;
                    end
                end
                S_DUMMY: if (rise) begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == dummyClks(s.op) - 5'h01) begin
                        n.cnt = '0;
                        n.st  = S_DATA;
                    end
                end
                S_DATA: if (fall) begin
                    n.ioOe = 4'hf;
                    if (!s.phase) begin
                        n.outByte = memRdData;
                        n.ioOut   = memRdData[7:4];
                        n.phase   = 1'b1;
                    end else begin
                        n.ioOut = s.outByte[3:0];
                        n.phase = 1'b0;
                        n.addr  = nextReadAddr(s.addr,
                                               !s.wrapDis && s.op != OP_READ_OCTAL,
                                               s.wrapLen);
                    end
                end
                S_WRAP_DUM: if (rise) begin
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == WRAP_DUM_LAST) begin
                        n.cnt = '0;
                        n.st  = S_WRAP_BITS;
                    end
                end
                S_WRAP_BITS: if (rise) begin
                    n.sh  = {s.sh[19:0], ioS};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == WRAP_BITS_LAST) begin
                        // bits 7 and 3:0 are not stored
                        n.wrapDis = wrapBits[WRAP_DIS_POS];
                        n.wrapLen = wrapBits[WRAP_LEN_HI:WRAP_LEN_LO];
                        n.st      = S_IGNORE;
                    end
                end
                S_PP_ADDR: if (rise) begin
                    n.sh  = {s.sh[22:0], io0};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == SADDR_LAST) begin
                        n.addr     = {s.sh[22:0], io0};
                        n.progAddr = {s.sh[22:0], io0};
                        n.cnt      = '0;
                        n.st       = S_PP_DATA;
                    end
                end
                S_PP_DATA: if (rise) begin
                    n.sh  = {s.sh[22:0], io0};
                    n.cnt = s.cnt + 5'h01;
                    if (s.cnt == BYTE_LAST) begin
                        bufWrEn      = 1'b1;
                        n.addr[7:0]  = s.addr[7:0] + 8'h01;
                        n.gotByte    = 1'b1;
                        n.cnt        = '0;
                    end
                end
                default: begin
                    n.st = S_IGNORE;
                end
            endcase
        end
    end

    // =====================================================================
    // state register; wrap starts disabled
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s         <= '0;
            s.st      <= S_IDLE;
            s.csPrev  <= 1'b1;
            s.wrapDis <= WRAP_DIS_RST;
            s.wrapLen <= WRAP_LEN_RST;
        end else begin
            s <= n;
        end
    end

    assign ioOut              = s.ioOut;
    assign ioOe               = s.ioOe;
    assign writeEnableLatch   = s.write_enable_latch;
    assign programBusyFlag    = s.busy;
    assign continuousReadMode = s.contMode;
    assign wrapDisableBit     = s.wrapDis;
    assign wrapLengthField    = s.wrapLen;
    assign progAddr           = s.progAddr;
    assign memRdAddr          = s.addr;
    assign arrWrEn            = s.arrWrEn;
    assign arrWrAddr          = s.arrWrAddr;
    assign arrWrData          = s.arrWrData;

    // =====================================================================
    // checks
    chk_word_dummy: assert property (
        @(posedge clk) disable iff (!reset_n)
        ($past(s.st) == S_DUMMY && s.st == S_DATA && s.op == OP_READ_WORD)
        |-> $past(s.cnt) == DUMMY_WORD - 5'h01)
        else $error("word read dummy count wrong");

    chk_quad_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s.st == S_OPCODE && rise && !csS && s.cnt == OP_LAST && !quadEnableBit)
        |=> s.st != S_ADDR)
        else $error("quad read accepted without quad enable");

    chk_cont_mode: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s.st == S_MODE && rise && !csS && s.cnt == MODE_LAST)
        |=> continuousReadMode == ($past(s.sh[1:0]) == MODE_CONT_CODE))
        else $error("continuous mode not taken from mode bits");

    chk_octal_nodum: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s.st == S_MODE && rise && !csS && s.cnt == MODE_LAST && s.op == OP_READ_OCTAL)
        |=> s.st == S_DATA)
        else $error("octal word read inserted dummy clocks");

    chk_wrap_reset: assert property (
        @(posedge clk) !reset_n |=> wrapDisableBit)
        else $error("wrap not disabled after reset");

    chk_page_wrap: assert property (
        @(posedge clk) disable iff (!reset_n)
        bufWrEn |=> s.addr[23:8] == $past(s.addr[23:8]))
        else $error("program address left its page");

    chk_busy_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(programBusyFlag) |-> programBusyFlag [*8])
        else $error("busy flag dropped early");

    chk_wel_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        ($fell(programBusyFlag) && !$past(welSet)) |-> !writeEnableLatch)
        else $error("write enable latch not cleared");

    chk_discard: assert property (
        @(posedge clk) disable iff (!reset_n)
        (csRise && s.st == S_PP_DATA && s.cnt != '0 && !s.busy) |=> !programBusyFlag)
        else $error("program started off a byte boundary");

endmodule : qwrp_sequencer

/* bench/qwrp_host_model.sv */
// host flash controller model: select, mode 0 serial clock, four lanes
// assumes a 20 MHz bench clock; serial clock stands low between frames
module qwrp_host_model (
    input  wire logic       clk,
    output logic            csN,
    output logic            sclk,
    output logic      [3:0] ioIn,
    input  wire logic [3:0] ioOut
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // pin tasks, every change on a falling clk edge
    initial begin
        csN  = 1'b1;
        sclk = 1'b0;
        ioIn = 4'h0;
    end
    // half serial period, 400 ns serial clock
    task automatic half;
        repeat (4) @(negedge clk);
    endtask : half
    // select edge with an idle gap on each side
    task automatic sel(input logic on);
        half();
        csN = !on;
        half();
    endtask : sel
    // one serial clock, lanes taken on the rising edge
    task automatic clk_nib(input logic [3:0] n);
        ioIn = n;
        half();
        sclk = 1'b1;
        half();
        sclk = 1'b0;
    endtask : clk_nib
    // lane zero msb first, idle lanes toggle
    task automatic send8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_nib({~ioIn[3:1], b[i]});
    endtask : send8
    // quad command; a zero opcode starts with the address
    task automatic quad_cmd(input logic [7:0] op, m, input logic [23:0] a, input int dum);
        if (op != 8'h00) send8(op);
        for (int i = 5; i >= 0; i--) clk_nib(a[4*i +: 4]);  // address or dummy bits
        clk_nib(m[7:4]);  // mode or wrap bits
        clk_nib(m[3:0]);
        repeat (dum) clk_nib(~ioIn);
    endtask : quad_cmd
    // read one byte, high nibble first
    task automatic read8(output logic [7:0] b);
        for (int i = 0; i < 2; i++) begin
            ioIn = ~ioIn;  // lanes toggled, no stale level
            half();
            b = {b[3:0], ioOut};
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
    endtask : read8
endmodule : qwrp_host_model

/* bench/test_qwrp_sequencer.sv */
// self-checking bench for the quad read, wrap and page program sequencer
// assumes the host model on the pins and an array returning address ^ 5a
module test_qwrp_sequencer
    import qwrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] w, op; logic [23:0] a; int dum;} qwrp_row_t;
    logic        clk, reset_n, csN, sclk, quadEnableBit, welSet, pageProtected, arrWrEn;
    logic        writeEnableLatch, programBusyFlag, continuousReadMode, wrapDisableBit;
    logic [1:0]  wrapLengthField;
    logic [3:0]  ioIn, ioOut, ioOe;
    logic [7:0]  memRdData, arrWrData, b, wr [logic [23:0]];
    logic [23:0] memRdAddr, arrWrAddr, progAddr;
    int          mismatches = 0, nChecks = 0;
    // wrap byte, opcode, start, dummies
    qwrp_row_t rows [6] = '{'{8'h10, OP_READ_QUAD, 24'h00003e, 4},
        '{8'h00, OP_READ_WORD, 24'h000046, 2}, '{8'h20, OP_READ_QUAD, 24'h00005c, 4},
        '{8'h60, OP_READ_WORD, 24'h00007e, 2}, '{8'h40, OP_READ_OCTAL, 24'h000090, 0},
        '{8'h8f, OP_READ_QUAD, 24'h0000fe, 4}};
    qwrp_sequencer #(.PROG_TIME_NS(20000)) qwrp_sequencer_inst (.clk, .reset_n, .csN, .sclk,
        .ioIn, .ioOut, .ioOe, .quadEnableBit, .welSet, .pageProtected, .writeEnableLatch,
        .programBusyFlag, .continuousReadMode, .wrapDisableBit, .wrapLengthField,
        .progAddr, .memRdAddr, .memRdData, .arrWrEn, .arrWrAddr, .arrWrData);
    qwrp_host_model qwrp_host_model_inst (.clk, .csN, .sclk, .ioIn, .ioOut);
    // ==========================================
    // array model and helpers
    assign memRdData = memRdAddr[7:0] ^ 8'h5a;
    // protection decode of the program address: the page block at 3000 is locked
    assign pageProtected = (progAddr[23:12] == 12'h003);
    always @(posedge clk) if (arrWrEn === 1'b1) wr[arrWrAddr] = arrWrData;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [23:0] got, exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // next read address under a wrap setting
    function automatic logic [23:0] nxt(logic [23:0] a, logic [7:0] w, op);
        logic [7:0] m;
        m = (8'h08 << w[6:5]) - 8'h01;
        if (w[4] || op == OP_READ_OCTAL) return a + 24'h1;
        return {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h1) & m)};
    endfunction : nxt
    // open frame: command, then n bytes checked
    task automatic rd(input logic [7:0] w, op, m, input logic [23:0] a, input int dum, n);
        qwrp_host_model_inst.sel(1'b1);
        qwrp_host_model_inst.quad_cmd(op, m, a, dum);
        for (int k = 0; k < n; k++) begin
            qwrp_host_model_inst.read8(b);
            chk(b, a[7:0] ^ 8'h5a);
            a = nxt(a, w, op);
        end
    endtask : rd
    task automatic desel;
        qwrp_host_model_inst.sel(1'b0);
    endtask : desel
    task automatic idle;
        for (int t = 0; t < 1000 && programBusyFlag !== 1'b0; t++) @(negedge clk);
        chk(programBusyFlag, 1'b0);
    endtask : idle
    // page program of n bytes plus stray bits
    task automatic prog(input logic [23:0] a, input int n, extra);
        welSet = 1'b1;
        @(negedge clk);
        welSet = 1'b0;
        chk(writeEnableLatch, 1'b1);
        qwrp_host_model_inst.sel(1'b1);
        qwrp_host_model_inst.send8(OP_PAGE_PROG);
        for (int i = 2; i >= 0; i--) qwrp_host_model_inst.send8(a[8*i +: 8]);
        for (int i = 0; i < n; i++) qwrp_host_model_inst.send8(8'ha0 + 8'(i));
        repeat (extra) qwrp_host_model_inst.clk_nib(4'h1);
        desel();
        for (int t = 0; t < 20 && programBusyFlag !== 1'b1; t++) @(negedge clk);
    endtask : prog
    task automatic finish_test;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // ==========================================
    // sequence and watchdog
    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end
    initial begin
        reset_n = 1'b0;
        quadEnableBit = 1'b1;
        welSet = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        chk(wrapDisableBit, 1'b1);
        foreach (rows[i]) begin
            rd(8'h00, OP_SET_WRAP, rows[i].w, 24'h0, 0, 0);
            desel();
            chk(wrapDisableBit, rows[i].w[4]);
            chk(wrapLengthField, rows[i].w[6:5]);
            rd(rows[i].w, rows[i].op, 8'h00, rows[i].a, rows[i].dum, 5);
            chk(ioOe, 4'hf);
            desel();
        end
        rd(8'h8f, OP_READ_WORD, 8'h2f, 24'h000200, 2, 1);
        desel();
        chk(continuousReadMode, 1'b1);
        rd(8'h8f, 8'h00, 8'hff, 24'h000310, 2, 1);
        desel();
        chk(continuousReadMode, 1'b0);
        quadEnableBit = 1'b0;
        rd(8'h8f, OP_READ_OCTAL, 8'h00, 24'h000400, 0, 0);
        qwrp_host_model_inst.half();
        chk(ioOe, 4'h0);
        desel();
        quadEnableBit = 1'b1;
        prog(24'h0012fe, 3, 0);
        chk(programBusyFlag, 1'b1);
        idle();
        chk(writeEnableLatch, 1'b0);
        chk(wr[24'h0012ff], 8'ha1);
        chk(wr[24'h001200], 8'ha2);
        prog(24'h002000, 1, 3);
        chk(programBusyFlag, 1'b0);
        prog(24'h003000, 1, 0);
        chk(progAddr, 24'h003000);
        idle();
        chk(1'(wr.exists(24'h003000)), 1'b0);
        finish_test();
    end
endmodule : test_qwrp_sequencer
